// ### core/tcc_pkg.sv
// Purpose: Shared constants and types of the timer count/interrupt control block
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes:   Offsets index byte registers; unused bits of clock enable and of start[3:0] read back as written
package tcc_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CLK_EN    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_START     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MASK      = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_REQ       = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PRIO_LO   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PRIO_HI   = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_GRA_LO    = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_GRA_HI    = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STAT_MASK = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_CNT_LO    = 4'ha;
    localparam logic [ADDR_W-1:0] OFS_CNT_HI    = 4'hb;

    // Field positions
    localparam int BIT_CLK_EN   = 4;
    localparam int BIT_RUN      = 0;
    localparam int BIT_CONT     = 2;
    localparam int BIT_CH0      = 1;
    localparam int BIT_ST_MATCH = 0;
    localparam int BIT_ST_STOP  = 1;
    localparam int STAT_W       = 2;

    // Reset values and write masks
    localparam logic [DATA_W-1:0] RST_CLK_EN    = 8'h00;
    localparam logic [DATA_W-1:0] RST_START     = 8'h00;
    localparam logic [DATA_W-1:0] START_WMASK   = 8'h0f;
    localparam logic [DATA_W-1:0] RST_MASK      = 8'hff;
    localparam logic [DATA_W-1:0] RST_REQ       = 8'h00;
    localparam logic [DATA_W-1:0] RST_PRIO      = 8'hff;
    localparam logic [CNT_W-1:0]  RST_GRA       = 16'hffff;
    localparam logic [STAT_W-1:0] RST_STAT_MASK = 2'h0;

    // Request forwarded to the processor with its level
    typedef struct packed {
        logic       req;
        logic [1:0] prio;
    } tcc_irq_s;

endpackage

// ### core/tcc_sticky_bits.sv
// Purpose: Vector of sticky flags, hardware set, software clear
// Assumes: Synchronous active-high reset
// Notes:   Set wins over clear in the same cycle
`timescale 1ns/1ps
module tcc_sticky_bits #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // Events and clears
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clear,
    // Flags
    output logic      [W-1:0] flags
);

    always_ff @(posedge clock) begin
        if (reset) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clear) | set;
        end
    end

endmodule

// ### core/tcc_cmp_counter.sv
// Purpose: Up counter that clears on a compare match
// Assumes: Count source is the system clock gated by enable
// Notes:   Match is combinational and only valid while enabled
`timescale 1ns/1ps
module tcc_cmp_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         reset,
    // Control
    input  wire logic         enable,
    input  wire logic [W-1:0] compare,
    // State
    output logic      [W-1:0] count,
    output logic              match
);

    assign match = enable && (count == compare);

    always_ff @(posedge clock) begin
        if (reset) begin
            count <= '0;
        end else if (match) begin
            count <= '0;
        end else if (enable) begin
            count <= count + 1'b1;
        end
    end

endmodule

// ### core/tcc_timer_ctrl.sv
// Purpose: Timer channel 0 clock gate, run control, compare stop and interrupt control
// Assumes: Register port strobes are one cycle; read data valid the cycle after
// Notes:   Interrupt controller registers stay writable while the timer is gated
//
// What this block does
// - Supply bit 0 gates clock, blocks timer writes
// - Supply bit 0 holds timer in reset
// - Supply bit 1 clocks timer, allows access
// - Continue bit 0 stops counter on match
// - Continue bit 1 keeps counting after match
// - Start register bit 0 runs counter
// - Mask bit 1 blocks, 0 allows servicing
// - Request flag 1 while pending, else 0
// - Two priority bits form code, 00 highest
// - Code 11 lowest, 01 and 10 middle
// - Compare match raises channel 0 request
`timescale 1ns/1ps
module tcc_timer_ctrl
    import tcc_pkg::*;
#(
    parameter int CW = CNT_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWriteData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regReadData,
    // Interrupts
    output logic                   irqLine,
    output tcc_irq_s               ch0TimerIrq,
    // Status
    output logic                   counterRunning
);

    logic [DATA_W-1:0] clockEnableReg;
    logic [DATA_W-1:0] startCtrl;
    logic [DATA_W-1:0] maskGroup;
    logic [DATA_W-1:0] reqGroup;
    logic [DATA_W-1:0] prioLow;
    logic [DATA_W-1:0] prioHigh;
    logic [CW-1:0]     graValue;
    logic [STAT_W-1:0] statMask;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] statSet;
    logic [STAT_W-1:0] statClear;
    logic [CW-1:0]     countValue;
    logic              cntMatch;
    logic              clockSupplyEn;
    logic              timerReset;
    logic              timerWrEn;
    logic              startWr;
    logic [DATA_W-1:0] next_readData;

    assign clockSupplyEn = clockEnableReg[BIT_CLK_EN];
    // Whole timer sits in reset while its clock is withheld
    assign timerReset    = reset || !clockSupplyEn;
    // Gated timer ignores writes; reads show reset values
    assign timerWrEn     = regWrite && clockSupplyEn;
    assign startWr       = timerWrEn && (regAddr == OFS_START);

    // Peripheral clock enable, always writable
    always_ff @(posedge clock) begin
        if (reset) begin
            clockEnableReg <= RST_CLK_EN;
        end else if (regWrite && regAddr == OFS_CLK_EN) begin
            clockEnableReg <= regWriteData;
        end
    end

    // Run flag and continue select; a software write beats a hardware stop
    always_ff @(posedge clock) begin
        if (timerReset) begin
            startCtrl <= RST_START;
        end else if (startWr) begin
            startCtrl <= regWriteData & START_WMASK;
        end else if (cntMatch && !startCtrl[BIT_CONT]) begin
            startCtrl[BIT_RUN] <= 1'b0;
        end
    end

    // Compare value
    always_ff @(posedge clock) begin
        if (timerReset) begin
            graValue <= RST_GRA;
        end else if (timerWrEn && regAddr == OFS_GRA_LO) begin
            graValue[7:0] <= regWriteData;
        end else if (timerWrEn && regAddr == OFS_GRA_HI) begin
            graValue[CW-1:8] <= regWriteData[CW-9:0];
        end
    end

    // Counter clocked only while supplied and running; clears on match
    tcc_cmp_counter #(
        .W(CW)
    ) u_counter (
        .clock  (clock),
        .reset  (timerReset),
        .enable (startCtrl[BIT_RUN]),
        .compare(graValue),
        .count  (countValue),
        .match  (cntMatch)
    );

    // Timer event status, write one to clear
    assign statSet   = {cntMatch && !startCtrl[BIT_CONT], cntMatch};
    assign statClear = (timerWrEn && regAddr == OFS_STATUS) ? regWriteData[STAT_W-1:0] : '0;

    tcc_sticky_bits #(
        .W(STAT_W)
    ) u_status (
        .clock(clock),
        .reset(timerReset),
        .set  (statSet),
        .clear(statClear),
        .flags(status)
    );

    always_ff @(posedge clock) begin
        if (timerReset) begin
            statMask <= RST_STAT_MASK;
        end else if (timerWrEn && regAddr == OFS_STAT_MASK) begin
            statMask <= regWriteData[STAT_W-1:0];
        end
    end

    // Interrupt controller group registers
    always_ff @(posedge clock) begin
        if (reset) begin
            maskGroup <= RST_MASK;
        end else if (regWrite && regAddr == OFS_MASK) begin
            maskGroup <= regWriteData;
        end
    end

    // Match sets the request even during a clearing write
    always_ff @(posedge clock) begin
        if (reset) begin
            reqGroup <= RST_REQ;
        end else begin
            if (regWrite && regAddr == OFS_REQ) begin
                reqGroup <= regWriteData;
            end
            if (cntMatch) begin
                reqGroup[BIT_CH0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prioLow  <= RST_PRIO;
            prioHigh <= RST_PRIO;
        end else if (regWrite && regAddr == OFS_PRIO_LO) begin
            prioLow  <= regWriteData;
        end else if (regWrite && regAddr == OFS_PRIO_HI) begin
            prioHigh <= regWriteData;
        end
    end

    // Read mux
    always_comb begin
        next_readData = '0;
        unique case (regAddr)
            OFS_CLK_EN:    next_readData = clockEnableReg;
            OFS_START:     next_readData = startCtrl;
            OFS_MASK:      next_readData = maskGroup;
            OFS_REQ:       next_readData = reqGroup;
            OFS_PRIO_LO:   next_readData = prioLow;
            OFS_PRIO_HI:   next_readData = prioHigh;
            OFS_GRA_LO:    next_readData = graValue[7:0];
            OFS_GRA_HI:    next_readData = graValue[CW-1:8];
            OFS_STATUS:    next_readData = {{(DATA_W-STAT_W){1'b0}}, status};
            OFS_STAT_MASK: next_readData = {{(DATA_W-STAT_W){1'b0}}, statMask};
            OFS_CNT_LO:    next_readData = countValue[7:0];
            OFS_CNT_HI:    next_readData = countValue[CW-1:8];
            default:       next_readData = '0;
        endcase
    end

    // Read data only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            regReadData <= '0;
        end else if (regRead) begin
            regReadData <= next_readData;
        end else begin
            regReadData <= '0;
        end
    end

    // Outputs registered; one cycle behind the flags
    always_ff @(posedge clock) begin
        if (reset) begin
            irqLine <= 1'b0;
        end else begin
            irqLine <= |(status & statMask);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ch0TimerIrq <= '0;
        end else begin
            ch0TimerIrq.req  <= reqGroup[BIT_CH0] && !maskGroup[BIT_CH0];
            ch0TimerIrq.prio <= {prioHigh[BIT_CH0], prioLow[BIT_CH0]};
        end
    end

    always_ff @(posedge clock) begin
        if (timerReset) begin
            counterRunning <= 1'b0;
        end else begin
            counterRunning <= startCtrl[BIT_RUN];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_gatedWrite;
        !clockSupplyEn && regWrite && (regAddr == OFS_START);
    endsequence

    sequence s_stopMatch;
        cntMatch && !startCtrl[BIT_CONT] && !startWr && clockSupplyEn;
    endsequence

    sequence s_keepMatch;
        cntMatch && startCtrl[BIT_CONT] && !startWr && clockSupplyEn;
    endsequence

    sequence s_runWrite;
        startWr && regWriteData[BIT_RUN];
    endsequence

    AST_GATED_WRITE: assert property (
        s_gatedWrite |=> startCtrl == RST_START
    ) else $error("Start register took a write while clock supply off");

    AST_HELD_RESET: assert property (
        (!clockSupplyEn && !$past(clockSupplyEn)) |-> (countValue == '0 && status == '0 && !counterRunning)
    ) else $error("Timer not held in reset while clock supply off");

    AST_WRITE_ACCEPT: assert property (
        (timerWrEn && regAddr == OFS_GRA_LO) |=> graValue[7:0] == $past(regWriteData)
    ) else $error("Compare register ignored a write while supplied");

    AST_STOP_ON_MATCH: assert property (
        s_stopMatch |=> (!startCtrl[BIT_RUN] && countValue == '0) ##1 (countValue == '0 || !clockSupplyEn)
    ) else $error("Counter kept running after match with continue off");

    AST_KEEP_ON_MATCH: assert property (
        s_keepMatch |=> (startCtrl[BIT_RUN] && countValue == '0)
    ) else $error("Counter stopped after match with continue on");

    AST_RUN_START: assert property (
        s_runWrite |=> startCtrl[BIT_RUN] ##1 counterRunning
    ) else $error("Run flag write did not start counter");

    AST_COUNT_ADVANCE: assert property (
        (startCtrl[BIT_RUN] && !cntMatch && clockSupplyEn) |=> countValue == $past(countValue) + 1'b1
    ) else $error("Running counter did not advance by one");

    AST_MASK_GATE: assert property (
        ch0TimerIrq.req |-> ($past(reqGroup[BIT_CH0]) && !$past(maskGroup[BIT_CH0]))
    ) else $error("Request forwarded while masked or not pending");

    AST_REQ_SET_WINS: assert property (
        cntMatch |=> reqGroup[BIT_CH0]
    ) else $error("Match did not leave request flag pending");

    AST_MATCH_TO_PROC: assert property (
        (cntMatch && !maskGroup[BIT_CH0] && !(regWrite && regAddr == OFS_MASK)) |=> ##1 ch0TimerIrq.req
    ) else $error("Unmasked match not forwarded within two cycles");

    AST_FORWARD: assert property (
        (reqGroup[BIT_CH0] && !maskGroup[BIT_CH0]) |=> ch0TimerIrq.req
    ) else $error("Unmasked pending request not forwarded");

    // Sampled reset in the antecedent: outputs still show reset values one edge after release
    AST_PRIO_CODE: assert property (
        !reset |=> ch0TimerIrq.prio == {$past(prioHigh[BIT_CH0]), $past(prioLow[BIT_CH0])}
    ) else $error("Forwarded priority differs from programmed bits");

    AST_PRIO_LOW: assert property (
        (!reset && prioHigh[BIT_CH0] && prioLow[BIT_CH0]) |=> ch0TimerIrq.prio == 2'h3
    ) else $error("Code 11 not forwarded as level 3");

    AST_PRIO_TOP: assert property (
        (!reset && !prioHigh[BIT_CH0] && !prioLow[BIT_CH0]) |=> ch0TimerIrq.prio == 2'h0
    ) else $error("Code 00 not forwarded as level 0");

    AST_IRQ_LINE: assert property (
        !reset |=> irqLine == |($past(status) & $past(statMask))
    ) else $error("Interrupt line disagrees with enabled status");

    // Clock gate: every timer register keeps its reset value
    AST_GATED_COMPARE: assert property (
        (!clockSupplyEn && regWrite && (regAddr == OFS_GRA_LO || regAddr == OFS_GRA_HI)) |=> graValue == RST_GRA
    ) else $error("Compare register took a write while clock supply off");

    AST_GATED_STAT_MASK: assert property (
        (!clockSupplyEn && regWrite && regAddr == OFS_STAT_MASK) |=> statMask == RST_STAT_MASK
    ) else $error("Status enable took a write while clock supply off");

    AST_GATE_STOPS_RUN: assert property (
        !clockSupplyEn |=> !startCtrl[BIT_RUN]
    ) else $error("Run flag survived a withheld clock supply");

    // Supplied timer: software write lands, even in a match cycle
    AST_START_WRITE: assert property (
        startWr |=> startCtrl == ($past(regWriteData) & START_WMASK)
    ) else $error("Start register ignored a write while supplied");

    AST_READ_IDLE_ZERO: assert property (
        !regRead |=> regReadData == '0
    ) else $error("Read data shown without a read strobe");

    // Event flags behind the interrupt
    AST_STOP_FLAG: assert property (
        s_stopMatch |=> status[BIT_ST_STOP]
    ) else $error("Stop on match not flagged in status");

    AST_MATCH_FLAG: assert property (
        (cntMatch && clockSupplyEn) |=> status[BIT_ST_MATCH]
    ) else $error("Compare match not flagged in status");

    AST_REQ_HOLD: assert property (
        (reqGroup[BIT_CH0] && !(regWrite && regAddr == OFS_REQ)) |=> reqGroup[BIT_CH0]
    ) else $error("Pending request dropped without a software clear");

    AST_REQ_CLEAR: assert property (
        (regWrite && regAddr == OFS_REQ && !regWriteData[BIT_CH0] && !cntMatch) |=> !reqGroup[BIT_CH0]
    ) else $error("Request flag still set after clearing write");

    AST_MASK_BLOCK: assert property (
        maskGroup[BIT_CH0] |=> !ch0TimerIrq.req
    ) else $error("Masked request forwarded to processor");

endmodule

// ### test/tb_tcc_timer_ctrl.sv
// Purpose: Self-checking bench for the timer control block
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Compare value is kept at 3 so matches come within a few cycles
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb_tcc_timer_ctrl import tcc_pkg::*; ;
    logic              clock;
    logic              reset;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWriteData;
    logic              regWrite;
    logic              regRead;
    logic [DATA_W-1:0] regReadData;
    logic              irqLine;
    tcc_irq_s          ch0TimerIrq;
    logic              counterRunning;
    int                bad_count;
    int                checks_done;

    tcc_timer_ctrl uut (
        .clock          (clock),
        .reset          (reset),
        .regAddr        (regAddr),
        .regWriteData   (regWriteData),
        .regWrite       (regWrite),
        .regRead        (regRead),
        .regReadData    (regReadData),
        .irqLine        (irqLine),
        .ch0TimerIrq    (ch0TimerIrq),
        .counterRunning (counterRunning)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        regAddr      <= a;
        regWriteData <= d;
        regWrite     <= 1'b1;
        @(posedge clock);
        regWrite     <= 1'b0;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string m);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        `CHK(regReadData, e, m)
    endtask

    // Registered outputs lag their cause by one cycle
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    // Bounded wait; a stuck run flag ends the run
    task automatic wait_run(input logic e);
        int n;
        n = 0;
        while (counterRunning !== e && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (counterRunning !== e) begin
            bad_count++;
            $display("CHECK FAILED at %0t: run flag wait timed out", $time);
            tally_and_finish();
        end
    endtask

    task automatic test_reset();
        rdchk(OFS_CLK_EN, RST_CLK_EN, "supply reset");
        rdchk(OFS_MASK, RST_MASK, "mask reset");
        rdchk(OFS_REQ, RST_REQ, "request reset");
        rdchk(OFS_PRIO_LO, RST_PRIO, "prio lo reset");
        rdchk(OFS_PRIO_HI, RST_PRIO, "prio hi reset");
        rdchk(4'hc, 8'h00, "unmapped read");
        `CHK(ch0TimerIrq.prio, 2'b11, "reset level")
        `CHK(ch0TimerIrq.req, 1'b0, "masked req")
    endtask

    task automatic test_gated();
        wr(OFS_START, 8'h01);
        wr(OFS_GRA_LO, 8'h03);
        settle();
        `CHK(counterRunning, 1'b0, "gated run")
        rdchk(OFS_START, RST_START, "gated start write");
        rdchk(OFS_GRA_LO, RST_GRA[7:0], "gated compare write");
    endtask

    task automatic test_stop_on_match();
        wr(OFS_CLK_EN, 8'h10);
        wr(OFS_REQ, 8'h00);
        wr(OFS_GRA_LO, 8'h03);
        wr(OFS_GRA_HI, 8'h00);
        rdchk(OFS_GRA_LO, 8'h03, "compare lo");
        rdchk(OFS_GRA_HI, 8'h00, "compare hi");
        wr(OFS_START, 8'h01);
        wait_run(1'b1);
        wait_run(1'b0);
        rdchk(OFS_START, 8'h00, "run cleared on match");
        rdchk(OFS_STATUS, 8'h03, "match and stop status");
        rdchk(OFS_REQ, 8'h02, "request set");
        rdchk(OFS_CNT_LO, 8'h00, "counter cleared");
        wr(OFS_CNT_LO, 8'h55);
        rdchk(OFS_CNT_LO, 8'h00, "counter read only");
    endtask

    task automatic test_irq_ctrl();
        logic [1:0] c;
        `CHK(irqLine, 1'b0, "status masked")
        wr(OFS_STAT_MASK, 8'h01);
        settle();
        `CHK(irqLine, 1'b1, "status enabled")
        wr(OFS_STATUS, 8'h01);
        settle();
        `CHK(irqLine, 1'b0, "status cleared")
        rdchk(OFS_STATUS, 8'h02, "w1c one bit");
        `CHK(ch0TimerIrq.req, 1'b0, "request masked")
        wr(OFS_MASK, 8'hfd);
        settle();
        `CHK(ch0TimerIrq.req, 1'b1, "request unmasked")
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(OFS_PRIO_LO, c[0] ? 8'hff : 8'hfd);
            wr(OFS_PRIO_HI, c[1] ? 8'hff : 8'hfd);
            settle();
            `CHK(ch0TimerIrq.prio, c, "priority code")
        end
        wr(OFS_REQ, 8'h00);
        settle();
        `CHK(ch0TimerIrq.req, 1'b0, "request cleared")
    endtask

    task automatic test_continue();
        wr(OFS_STATUS, 8'h03);
        wr(OFS_START, 8'h05);
        repeat (20) @(posedge clock);
        #1;
        `CHK(counterRunning, 1'b1, "keeps running")
        rdchk(OFS_START, 8'h05, "run kept");
        rdchk(OFS_STATUS, 8'h01, "match without stop");
        rdchk(OFS_REQ, 8'h02, "request raised");
        `CHK(ch0TimerIrq.req, 1'b1, "request forwarded")
        wr(OFS_START, 8'h04);
        wait_run(1'b0);
        wr(OFS_START, 8'h05);
        wait_run(1'b1);
        // Gating mid-run must reset the whole timer
        wr(OFS_CLK_EN, 8'h00);
        settle();
        `CHK(counterRunning, 1'b0, "gate stops run")
        rdchk(OFS_START, RST_START, "start reset by gate");
        rdchk(OFS_STATUS, 8'h00, "status reset by gate");
        rdchk(OFS_GRA_LO, RST_GRA[7:0], "compare reset by gate");
        rdchk(OFS_MASK, 8'hfd, "mask kept");
    endtask

    initial begin
        reset        = 1'b1;
        regAddr      = '0;
        regWriteData = '0;
        regWrite     = 1'b0;
        regRead      = 1'b0;
        bad_count    = 0;
        checks_done  = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        test_reset();
        test_gated();
        test_stop_on_match();
        test_irq_ctrl();
        test_continue();
        tally_and_finish();
    end
endmodule
